// ---- hdl/frwvo_regs.sv ----
/*
 * Register slice at 0x2a..0x32: frame rate trim (high/low), white balance
 * policy and band filter control, V channel offset, and reserved bytes.
 * Registers are reached over a simple byte-wide write/read port driven by the
 * serial control bus front end, which is assumed synchronous to CLK.
 * Frame start, settling status and black-level loop value come from the
 * sensor core on the same clock.
 */
// Operation
// - Trim value is 10 bits; low 8 bits live at offset 0x2b.
// - Each trim step lowers frame rate by 0.21 percent of nominal.
// - Trim covers 0.21 percent up to 109 percent.
// - Control bit 3 set: white balance updates only after exposure/gain settle.
// - Control bit 2 set: exposure uses anti-banding algorithm.
// - V offset bit 7 picks add or subtract of bits 6..0.
// - V offset spans plus 128 mV to minus 128 mV.
// - Source bit clear: black-level loop writes offset, bus writes ignored.
// - Common control F bit 1 set: offset has no effect on output.
// - Raw RGB format: offset applies to red, green and blue samples.
// - Trim high bit 7 enables trim; clear means trim has no effect.
// - Trim high bit 5 is the trim value's top bit.
`timescale 1ns/1ps
`include "frwvo_cfg.svh"

module frwvo_regs
    import frwvo_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire frwvo_byte_t ADDR,
    input wire frwvo_byte_t WDATA,
    output frwvo_byte_t RDATA,
    output logic RVALID,
    input wire logic FRAME_START,
    input wire logic AE_AG_SETTLED,
    input wire logic WB_UPDATE_REQ,
    input wire logic OFFSET_SOURCE_CTRL,
    input wire logic COMMON_CTRL_F_BIT1,
    input wire frwvo_byte_t BLACK_LEVEL_LOOP,
    input wire logic BLACK_LEVEL_LOOP_VALID,
    input wire frwvo_fmt_t OUT_FMT,
    input wire logic SAMPLE_IS_V,
    input wire frwvo_byte_t SAMPLE_IN,
    output frwvo_byte_t SAMPLE_OUT,
    output frwvo_trim_t TRIM_ACTIVE,
    output logic TRIM_ENABLE,
    output logic BAND_FILTER_EN,
    output logic WB_UPDATE
);
    frwvo_byte_t trim_high, next_trim_high;
    frwvo_byte_t trim_low, next_trim_low;
    frwvo_byte_t rsvd_2c, next_rsvd_2c;
    frwvo_byte_t wb_ctrl, next_wb_ctrl;
    frwvo_byte_t v_offset, next_v_offset;
    frwvo_byte_t rsvd_hi [0:3];
    frwvo_byte_t next_rsvd_hi [0:3];
    frwvo_byte_t next_rdata;
    logic next_rvalid;
    frwvo_trim_t next_trim_active;
    logic next_trim_enable;
    logic next_band_filter_en;
    frwvo_wb_state_t wb_state, next_wb_state;
    logic next_wb_update;
    logic apply_offset;
    frwvo_byte_t applied_sample;

    function automatic logic hit_rsvd_hi(input frwvo_byte_t a);
        hit_rsvd_hi = (a >= `FRWVO_OFF_RSVD_FIRST) && (a <= `FRWVO_OFF_RSVD_LAST);
    endfunction : hit_rsvd_hi

    function automatic logic [1:0] rsvd_index(input frwvo_byte_t a);
        frwvo_byte_t d;
        d = a - `FRWVO_OFF_RSVD_FIRST;
        rsvd_index = d[1:0];
    endfunction : rsvd_index

    // Register writes and read data
    always_comb
    begin
        next_trim_high = trim_high;
        next_trim_low = trim_low;
        next_rsvd_2c = rsvd_2c;
        next_wb_ctrl = wb_ctrl;
        next_v_offset = v_offset;
        for (int i = 0; i < 4; i++)
            next_rsvd_hi[i] = rsvd_hi[i];
        if (WR_EN)
        begin
            case (ADDR)
                `FRWVO_OFF_TRIM_HIGH: next_trim_high = WDATA;
                `FRWVO_OFF_TRIM_LOW: next_trim_low = WDATA;
                `FRWVO_OFF_RSVD_2C: next_rsvd_2c = WDATA;
                `FRWVO_OFF_WB_CTRL: next_wb_ctrl = WDATA;
                `FRWVO_OFF_V_OFFSET:
                begin
                    if (OFFSET_SOURCE_CTRL)
                        next_v_offset = WDATA;
                end
                default:
                begin
                    if (hit_rsvd_hi(ADDR))
                        next_rsvd_hi[rsvd_index(ADDR)] = WDATA;
                end
            endcase
        end
        // The loop owns the offset while the source bit is clear
        if (!OFFSET_SOURCE_CTRL && BLACK_LEVEL_LOOP_VALID)
            next_v_offset = BLACK_LEVEL_LOOP;
        next_rvalid = RD_EN;
        next_rdata = 8'h00;
        if (RD_EN)
        begin
            case (ADDR)
                `FRWVO_OFF_TRIM_HIGH: next_rdata = trim_high;
                `FRWVO_OFF_TRIM_LOW: next_rdata = trim_low;
                `FRWVO_OFF_RSVD_2C: next_rdata = rsvd_2c;
                `FRWVO_OFF_WB_CTRL: next_rdata = wb_ctrl;
                `FRWVO_OFF_V_OFFSET: next_rdata = v_offset;
                default:
                begin
                    if (hit_rsvd_hi(ADDR))
                        next_rdata = rsvd_hi[rsvd_index(ADDR)];
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            trim_high <= `FRWVO_RST_TRIM_HIGH;
            trim_low <= `FRWVO_RST_TRIM_LOW;
            rsvd_2c <= `FRWVO_RST_RSVD_2C;
            wb_ctrl <= `FRWVO_RST_WB_CTRL;
            v_offset <= `FRWVO_RST_V_OFFSET;
            for (int i = 0; i < 4; i++)
                rsvd_hi[i] <= `FRWVO_RST_RSVD_HI;
            RDATA <= 8'h00;
            RVALID <= 1'b0;
        end
        else
        begin
            trim_high <= next_trim_high;
            trim_low <= next_trim_low;
            rsvd_2c <= next_rsvd_2c;
            wb_ctrl <= next_wb_ctrl;
            v_offset <= next_v_offset;
            for (int i = 0; i < 4; i++)
                rsvd_hi[i] <= next_rsvd_hi[i];
            RDATA <= next_rdata;
            RVALID <= next_rvalid;
        end
    end

    // Frame timing: trim is latched only at frame start so no frame mixes timings.
    // Software is expected to keep common control E bit 7 clear when enabling.
    always_comb
    begin
        next_trim_active = TRIM_ACTIVE;
        next_trim_enable = TRIM_ENABLE;
        next_band_filter_en = wb_ctrl[`FRWVO_BIT_BAND_FILTER];
        if (FRAME_START)
        begin
            next_trim_enable = trim_high[`FRWVO_BIT_TRIM_EN];
            // Disabled trim reads as zero steps, i.e. nominal rate (0.21 % per step)
            // Bit 8 has no register bit behind it and reads as zero
            if (trim_high[`FRWVO_BIT_TRIM_EN])
                next_trim_active = {trim_high[`FRWVO_BIT_TRIM_MSB], 1'b0,
                    trim_low};
            else
                next_trim_active = 10'h000;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            TRIM_ACTIVE <= 10'h000;
            TRIM_ENABLE <= 1'b0;
            BAND_FILTER_EN <= 1'b0;
        end
        else
        begin
            TRIM_ACTIVE <= next_trim_active;
            TRIM_ENABLE <= next_trim_enable;
            BAND_FILTER_EN <= next_band_filter_en;
        end
    end

    // White balance update gating: a held request waits for settling when policy asks
    always_comb
    begin
        next_wb_state = wb_state;
        next_wb_update = 1'b0;
        case (wb_state)
            FRWVO_WB_IDLE:
            begin
                if (WB_UPDATE_REQ)
                begin
                    if (!wb_ctrl[`FRWVO_BIT_WB_SETTLED] || AE_AG_SETTLED)
                    begin
                        next_wb_update = 1'b1;
                        next_wb_state = FRWVO_WB_PULSE;
                    end
                    else
                        next_wb_state = FRWVO_WB_WAIT;
                end
            end
            FRWVO_WB_WAIT:
            begin
                if (!wb_ctrl[`FRWVO_BIT_WB_SETTLED] || AE_AG_SETTLED)
                begin
                    next_wb_update = 1'b1;
                    next_wb_state = FRWVO_WB_PULSE;
                end
            end
            FRWVO_WB_PULSE: next_wb_state = FRWVO_WB_IDLE;
            default: next_wb_state = FRWVO_WB_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            wb_state <= FRWVO_WB_IDLE;
            WB_UPDATE <= 1'b0;
        end
        else
        begin
            wb_state <= next_wb_state;
            WB_UPDATE <= next_wb_update;
        end
    end

    // Offset touches V samples, or every sample in raw RGB output
    assign apply_offset = !COMMON_CTRL_F_BIT1
        && ((OUT_FMT == FRWVO_FMT_RAW) || SAMPLE_IS_V);

    frwvo_offset_apply frwvo_offset_apply_inst
    (
        .clk(CLK),
        .rst_b(RST_B),
        .bypass(!apply_offset),
        .offset(v_offset),
        .sample_in(SAMPLE_IN),
        .sample_out(applied_sample)
    );

    always_ff @(posedge CLK)
    begin
        if (!RST_B)
            SAMPLE_OUT <= 8'h00;
        else
            SAMPLE_OUT <= applied_sample;
    end

    trim_frame_only_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !FRAME_START |=> $stable(TRIM_ACTIVE))
        else $error("trim changed outside frame start");
    trim_value_a: assert property (@(posedge CLK) disable iff (!RST_B)
        FRAME_START && trim_high[7] |=> TRIM_ACTIVE == {$past(trim_high[5]), 1'b0, $past(trim_low)})
        else $error("trim value wrong");
    trim_disable_a: assert property (@(posedge CLK) disable iff (!RST_B)
        FRAME_START && !trim_high[7] |=> TRIM_ACTIVE == 10'h000 && !TRIM_ENABLE)
        else $error("disabled trim not zero");
    trim_msb_a: assert property (@(posedge CLK) disable iff (!RST_B)
        FRAME_START && trim_high[7] |=> TRIM_ACTIVE[9] == $past(trim_high[5]))
        else $error("trim top bit wrong");
    band_filter_a: assert property (@(posedge CLK) disable iff (!RST_B)
        ##1 BAND_FILTER_EN == $past(wb_ctrl[2]))
        else $error("band filter enable wrong");
    wb_wait_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WB_UPDATE && $past(wb_ctrl[`FRWVO_BIT_WB_SETTLED]) |-> $past(AE_AG_SETTLED))
        else $error("white balance updated before settling");
    wb_free_a: assert property (@(posedge CLK) disable iff (!RST_B)
        wb_state == FRWVO_WB_IDLE && WB_UPDATE_REQ && !wb_ctrl[3] |=> WB_UPDATE)
        else $error("independent white balance update missing");
    bus_ignored_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WR_EN && ADDR == 8'h2e && !OFFSET_SOURCE_CTRL && !BLACK_LEVEL_LOOP_VALID |=> $stable(v_offset))
        else $error("offset written while loop owns it");
    bus_write_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WR_EN && ADDR == 8'h2e && OFFSET_SOURCE_CTRL |=> v_offset == $past(WDATA))
        else $error("stored offset write lost");
    rsvd_readback_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WR_EN && ADDR == `FRWVO_OFF_RSVD_2C ##1 !WR_EN ##1 RD_EN && ADDR == `FRWVO_OFF_RSVD_2C && !WR_EN
            |=> RDATA == $past(WDATA, 3))
        else $error("reserved readback wrong");
    offset_bypass_a: assert property (@(posedge CLK) disable iff (!RST_B)
        COMMON_CTRL_F_BIT1 |=> ##1 SAMPLE_OUT == $past(SAMPLE_IN, 2))
        else $error("offset applied while disabled");

    frame_trim_c: cover property (@(posedge CLK) disable iff (!RST_B) FRAME_START && trim_high[7]);
    wb_wait_c: cover property (@(posedge CLK) disable iff (!RST_B) wb_state == FRWVO_WB_WAIT ##1 WB_UPDATE);
    loop_write_c: cover property (@(posedge CLK) disable iff (!RST_B) !OFFSET_SOURCE_CTRL && BLACK_LEVEL_LOOP_VALID);
    raw_offset_c: cover property (@(posedge CLK) disable iff (!RST_B) OUT_FMT == FRWVO_FMT_RAW && !COMMON_CTRL_F_BIT1);
endmodule : frwvo_regs

// ---- hdl/frwvo_cfg.svh ----
/*
 * Register offsets, field positions, reset values and timing figures for the
 * frame rate trim, white balance policy and V offset register slice.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef FRWVO_CFG_SVH
`define FRWVO_CFG_SVH

`define FRWVO_ADDR_W 8
`define FRWVO_DATA_W 8

`define FRWVO_OFF_TRIM_HIGH 8'h2a
`define FRWVO_OFF_TRIM_LOW 8'h2b
`define FRWVO_OFF_RSVD_2C 8'h2c
`define FRWVO_OFF_WB_CTRL 8'h2d
`define FRWVO_OFF_V_OFFSET 8'h2e
`define FRWVO_OFF_RSVD_FIRST 8'h2f
`define FRWVO_OFF_RSVD_LAST 8'h32

`define FRWVO_RST_TRIM_HIGH 8'h84
`define FRWVO_RST_TRIM_LOW 8'h5e
`define FRWVO_RST_RSVD_2C 8'h88
`define FRWVO_RST_WB_CTRL 8'h03
`define FRWVO_RST_V_OFFSET 8'h80
`define FRWVO_RST_RSVD_HI 8'h00

`define FRWVO_BIT_TRIM_EN 7
`define FRWVO_BIT_TRIM_MSB 5
`define FRWVO_BIT_WB_SETTLED 3
`define FRWVO_BIT_BAND_FILTER 2
`define FRWVO_BIT_V_SIGN 7
`define FRWVO_V_MAG_W 7

// Step of the frame rate trim in hundredths of a percent; span of the trim
`define FRWVO_TRIM_STEP_CPCT 21
`define FRWVO_TRIM_MIN_CPCT 21
`define FRWVO_TRIM_MAX_CPCT 10900
// Offset full scale in millivolts for a full 7-bit magnitude
`define FRWVO_V_SPAN_MV 128

`endif

// ---- hdl/frwvo_pkg.sv ----
/*
 * Types shared by the register slice: the trim value and the output
 * sample format selector.
 * Assumes the constants header is on the include path.
 */
`include "frwvo_cfg.svh"

package frwvo_pkg;
    typedef logic [9:0] frwvo_trim_t;
    typedef logic [`FRWVO_DATA_W-1:0] frwvo_byte_t;
    typedef enum logic [1:0]
    {
        FRWVO_FMT_YUV = 2'b00,
        FRWVO_FMT_GRB = 2'b01,
        FRWVO_FMT_RAW = 2'b10
    } frwvo_fmt_t;
    typedef enum logic [1:0]
    {
        FRWVO_WB_IDLE = 2'b00,
        FRWVO_WB_WAIT = 2'b01,
        FRWVO_WB_PULSE = 2'b10
    } frwvo_wb_state_t;
endpackage : frwvo_pkg

// ---- hdl/frwvo_offset_apply.sv ----
/*
 * Applies the sign/magnitude V offset to one 8-bit sample with saturation.
 * Assumes the sample and offset are synchronous to the caller's clock.
 */
`timescale 1ns/1ps
`include "frwvo_cfg.svh"

module frwvo_offset_apply
    import frwvo_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic bypass,
    input wire frwvo_byte_t offset,
    input wire frwvo_byte_t sample_in,
    output frwvo_byte_t sample_out
);
    frwvo_byte_t next_sample_out;
    logic [9:0] sum;

    always_comb
    begin
        // Bit 7 picks direction, bits 6..0 the magnitude
        if (offset[`FRWVO_BIT_V_SIGN])
            sum = {2'b00, sample_in} - {3'b000, offset[`FRWVO_V_MAG_W-1:0]};
        else
            sum = {2'b00, sample_in} + {3'b000, offset[`FRWVO_V_MAG_W-1:0]};
        if (bypass)
            next_sample_out = sample_in;
        else if (sum[9])
            next_sample_out = 8'h00;
        else if (sum[8])
            next_sample_out = 8'hff;
        else
            next_sample_out = sum[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
            sample_out <= 8'h00;
        else
            sample_out <= next_sample_out;
    end

    bypass_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
        bypass |=> sample_out == $past(sample_in))
        else $error("bypass did not pass sample through");
endmodule : frwvo_offset_apply

// ---- bench/frwvo_regs_test.sv ----
/*
 * Self-checking bench for the frame rate trim, white balance policy and
 * V offset register slice: register reads and writes, frame-latched trim,
 * white balance gating and the sample offset path.
 * Assumes the package and constants header are compiled alongside.
 */
`timescale 1ns/1ps
`include "frwvo_cfg.svh"

module frwvo_regs_test
    import frwvo_pkg::*;
();
    logic clk, rst_b, wr_en, rd_en, frame_start, settled, wb_req;
    logic src_ctrl, f_bit1, loop_valid, sample_is_v;
    logic rvalid, trim_en, band_en, wb_update;
    frwvo_byte_t addr, wdata, rdata, loop_val, sample_in, sample_out;
    frwvo_trim_t trim_active;
    frwvo_fmt_t out_fmt;
    int err_count, num_checks, cycles, hits;

    frwvo_regs frwvo_regs_inst (.CLK(clk), .RST_B(rst_b), .WR_EN(wr_en),
        .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
        .RVALID(rvalid), .FRAME_START(frame_start), .AE_AG_SETTLED(settled),
        .WB_UPDATE_REQ(wb_req), .OFFSET_SOURCE_CTRL(src_ctrl),
        .COMMON_CTRL_F_BIT1(f_bit1), .BLACK_LEVEL_LOOP(loop_val),
        .BLACK_LEVEL_LOOP_VALID(loop_valid), .OUT_FMT(out_fmt),
        .SAMPLE_IS_V(sample_is_v), .SAMPLE_IN(sample_in),
        .SAMPLE_OUT(sample_out), .TRIM_ACTIVE(trim_active),
        .TRIM_ENABLE(trim_en), .BAND_FILTER_EN(band_en),
        .WB_UPDATE(wb_update));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task print_verdict;
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Ceiling well above the roughly 160 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task check_val(input logic [9:0] got, input logic [9:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check_val

    task wr(input frwvo_byte_t a, input frwvo_byte_t d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task rd(input frwvo_byte_t a, input frwvo_byte_t exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check_val({9'h000, rvalid}, 10'h001);
        check_val({2'b00, rdata}, {2'b00, exp});
    endtask : rd

    // Trim outputs stand until the next boundary, so one spare edge is safe
    task frame(input frwvo_trim_t exp, input logic en);
        @(posedge clk);
        frame_start <= 1'b1;
        @(posedge clk);
        frame_start <= 1'b0;
        @(posedge clk);
        #1;
        check_val(trim_active, exp);
        check_val({9'h000, trim_en}, {9'h000, en});
    endtask : frame

    // Input held steady so the pipeline depth does not matter
    task smp(input frwvo_byte_t s, input frwvo_byte_t exp);
        @(posedge clk);
        sample_in <= s;
        repeat (4) @(posedge clk);
        #1;
        check_val({2'b00, sample_out}, {2'b00, exp});
    endtask : smp

    task req_wb(input logic exp);
        @(posedge clk);
        wb_req <= 1'b1;
        @(posedge clk);
        wb_req <= 1'b0;
        #1;
        check_val({9'h000, wb_update}, {9'h000, exp});
    endtask : req_wb

    task count_wb(input int n);
        hits = 0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            if (wb_update === 1'b1)
                hits++;
        end
    endtask : count_wb

    initial
    begin
        {rst_b, wr_en, rd_en, frame_start, settled, wb_req} = '0;
        {src_ctrl, f_bit1, loop_valid, sample_is_v} = '0;
        {addr, wdata, loop_val, sample_in} = '0;
        out_fmt = FRWVO_FMT_YUV;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd(`FRWVO_OFF_TRIM_HIGH, `FRWVO_RST_TRIM_HIGH);
        rd(`FRWVO_OFF_TRIM_LOW, `FRWVO_RST_TRIM_LOW);
        rd(`FRWVO_OFF_RSVD_2C, `FRWVO_RST_RSVD_2C);
        rd(`FRWVO_OFF_WB_CTRL, `FRWVO_RST_WB_CTRL);
        rd(`FRWVO_OFF_V_OFFSET, `FRWVO_RST_V_OFFSET);
        check_val({9'h000, band_en}, 10'h000);
        for (int a = 8'h2f; a <= 8'h32; a++)
            rd(a[7:0], `FRWVO_RST_RSVD_HI);
        wr(8'h33, 8'hff);
        rd(8'h33, 8'h00);
        wr(`FRWVO_OFF_RSVD_2C, 8'h5a);
        rd(`FRWVO_OFF_RSVD_2C, 8'h5a);
        for (int a = 8'h2f; a <= 8'h32; a++)
        begin
            wr(a[7:0], a[7:0] ^ 8'ha5);
            rd(a[7:0], a[7:0] ^ 8'ha5);
        end
        // Trim latched only at frame boundaries
        // Common control E bit 7 lives outside this slice and is kept clear
        wr(`FRWVO_OFF_TRIM_HIGH, 8'ha0);
        wr(`FRWVO_OFF_TRIM_LOW, 8'h34);
        check_val(trim_active, 10'h000);
        frame(10'h234, 1'b1);
        wr(`FRWVO_OFF_TRIM_LOW, 8'h00);
        wr(`FRWVO_OFF_TRIM_HIGH, 8'h80);
        check_val(trim_active, 10'h234);
        frame(10'h000, 1'b1);
        wr(`FRWVO_OFF_TRIM_HIGH, 8'ha0);
        wr(`FRWVO_OFF_TRIM_LOW, 8'hff);
        frame(10'h2ff, 1'b1);
        wr(`FRWVO_OFF_TRIM_HIGH, 8'h20);
        frame(10'h000, 1'b0);
        // Band filter and white balance policy
        wr(`FRWVO_OFF_WB_CTRL, 8'h04);
        repeat (2) @(posedge clk);
        check_val({9'h000, band_en}, 10'h001);
        wr(`FRWVO_OFF_WB_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        check_val({9'h000, band_en}, 10'h000);
        req_wb(1'b1);
        wr(`FRWVO_OFF_WB_CTRL, 8'h08);
        req_wb(1'b0);
        count_wb(4);
        check_val(hits[9:0], 10'h000);
        @(posedge clk);
        settled <= 1'b1;
        count_wb(3);
        check_val(hits[9:0], 10'h001);
        req_wb(1'b1);
        // Stored offset path
        src_ctrl <= 1'b1;
        sample_is_v <= 1'b1;
        wr(`FRWVO_OFF_V_OFFSET, 8'h05);
        smp(8'h10, 8'h15);
        smp(8'hfe, 8'hff);
        wr(`FRWVO_OFF_V_OFFSET, 8'h85);
        smp(8'h10, 8'h0b);
        smp(8'h02, 8'h00);
        wr(`FRWVO_OFF_V_OFFSET, 8'hff);
        smp(8'hff, 8'h80);
        f_bit1 <= 1'b1;
        smp(8'h40, 8'h40);
        f_bit1 <= 1'b0;
        sample_is_v <= 1'b0;
        smp(8'h40, 8'h40);
        out_fmt <= FRWVO_FMT_RAW;
        smp(8'h40, 8'h00);
        out_fmt <= FRWVO_FMT_GRB;
        smp(8'h40, 8'h40);
        // Loop-owned offset ignores bus writes
        src_ctrl <= 1'b0;
        wr(`FRWVO_OFF_V_OFFSET, 8'h01);
        rd(`FRWVO_OFF_V_OFFSET, 8'hff);
        @(posedge clk);
        loop_val <= 8'h83;
        loop_valid <= 1'b1;
        @(posedge clk);
        loop_valid <= 1'b0;
        rd(`FRWVO_OFF_V_OFFSET, 8'h83);
        out_fmt <= FRWVO_FMT_RAW;
        smp(8'h10, 8'h0d);
        print_verdict();
    end
endmodule : frwvo_regs_test
